// [rtl/ewsc_top.sv]
// exterior open/close arbitration, window command and hall position logic
`timescale 1ns/10ps
`include "ewsc_params.svh"
module ewsc_top #(
  parameter logic [15:0] TICK_CYCLES = 16'(`EWSC_TICK_CYCLES),
  parameter logic [15:0] GRACE_TICKS = 16'(`EWSC_GRACE_TICKS),
  parameter logic [`EWSC_DB_W-1:0] DB_CYCLES = `EWSC_DB_W'(`EWSC_DB_CYCLES),
  parameter logic [`EWSC_POS_W-1:0] FULL_OPEN_PULSES = `EWSC_FULL_OPEN_PULSES,
  parameter int PULSES_PER_MM = `EWSC_PULSES_PER_MM
) (
  input wire logic clk,
  input wire logic srst,
  input wire ewsc_pkg::ewsc_ext_in_t ext_in,
  input wire ewsc_pkg::ewsc_win_in_t win_in,
  input wire ewsc_pkg::ewsc_hall_t hall_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output ewsc_pkg::ewsc_cmd_t win_req,
  output ewsc_pkg::ewsc_cmd_t roof_cmd,
  output logic [3:0] win_open,
  output logic [3:0] win_close
);
  localparam int NSW = $bits(ewsc_pkg::ewsc_ext_in_t) + $bits(ewsc_pkg::ewsc_win_in_t);
  localparam int NHALL = $bits(ewsc_pkg::ewsc_hall_t);
  localparam logic [`EWSC_POS_W-1:0] REV_PULSES = `EWSC_POS_W'(`EWSC_REV_MM * PULSES_PER_MM);

  ewsc_pkg::ewsc_state_t st_reg;
  ewsc_pkg::ewsc_state_t st_next;
  ewsc_pkg::ewsc_ext_in_t e;
  ewsc_pkg::ewsc_win_in_t w;
  ewsc_pkg::ewsc_hall_t h;
  logic [NSW-1:0] sw_raw;
  logic [NSW-1:0] sw_deb;
  logic [NHALL-1:0] hall_deb;

  assign sw_raw = {ext_in, win_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSW; gi++) begin : g_sw
      ewsc_debounce #(.DB_CYCLES(DB_CYCLES)) u_db (
        .clk(clk),
        .srst(srst),
        .pin(sw_raw[gi]),
        .q(sw_deb[gi])
      );
    end
    for (gi = 0; gi < NHALL; gi++) begin : g_hall
      ewsc_debounce #(.DB_CYCLES(`EWSC_DB_W'(`EWSC_HALL_DB_CYCLES))) u_db (
        .clk(clk),
        .srst(srst),
        .pin(hall_in[gi]),
        .q(hall_deb[gi])
      );
    end
  endgenerate

  assign {e, w} = sw_deb;
  assign h = hall_deb;

  // hold timer: clears on release, saturates at the target
  function automatic logic [15:0] hold_cnt(input logic lvl, input logic tk, input logic [15:0] c,
                                           input logic [15:0] tgt);
    if (!lvl) begin
      hold_cnt = '0;
    end else if (tk && c < tgt) begin
      hold_cnt = c + 16'h0001;
    end else begin
      hold_cnt = c;
    end
  endfunction : hold_cnt

  always_comb begin
    logic inhibit;
    logic interior;
    logic ign_ok;
    logic open_ok;
    logic closed_all;
    logic tx_rise;
    logic tx_qual;
    logic ul_q;
    logic lk_q;
    logic req_q;
    logic opening;
    logic closing;
    logic a_edge;
    logic b_edge;
    logic a_rise;
    logic moving;
    logic stalled;
    logic man_o;
    logic man_c;
    logic ext_o;
    logic ext_c;
    logic auto_ok;
    logic bus_req;
    logic fail_set;
    inhibit = 1'b0;
    interior = 1'b0;
    ign_ok = 1'b0;
    open_ok = 1'b0;
    closed_all = 1'b0;
    tx_rise = 1'b0;
    tx_qual = 1'b0;
    ul_q = 1'b0;
    lk_q = 1'b0;
    req_q = 1'b0;
    opening = 1'b0;
    closing = 1'b0;
    a_edge = 1'b0;
    b_edge = 1'b0;
    a_rise = 1'b0;
    moving = 1'b0;
    stalled = 1'b0;
    man_o = 1'b0;
    man_c = 1'b0;
    ext_o = 1'b0;
    ext_c = 1'b0;
    auto_ok = 1'b0;
    bus_req = 1'b0;
    fail_set = 1'b0;
    st_next = st_reg;

    // fixed time base
    if (st_reg.tick_cnt >= TICK_CYCLES - 16'h0001) begin
      st_next.tick_cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
      st_next.tick = 1'b0;
    end

    // ignition-off grace; a door opening ends it early
    st_next.ign_prev = e.ign_on;
    if (st_reg.ign_prev && !e.ign_on) begin
      st_next.grace = 1'b1;
      st_next.grace_cnt = '0;
    end else if (st_reg.grace) begin
      if (st_reg.tick) begin
        st_next.grace_cnt = st_reg.grace_cnt + 16'h0001;
      end
      if (st_reg.grace_cnt >= GRACE_TICKS || e.door_open || e.ign_on) begin
        st_next.grace = 1'b0;
      end
    end
    ign_ok = e.ign_on | st_reg.grace;
    interior = ign_ok & (|w.main_open | |w.main_close | |w.sub_open | |w.sub_close);

    inhibit = e.door_open | e.key_inserted | e.ign_on | e.tx_out_of_range | ~st_reg.ext_en;
    open_ok = ~(e.glass_full_open & e.roof_full_open);
    closed_all = e.glass_closed & e.roof_closed;

    // transmitter double press
    st_next.tx_prev = e.tx_unlock;
    tx_rise = e.tx_unlock & ~st_reg.tx_prev;
    tx_qual = tx_rise & st_reg.tx_armed & (st_reg.tx_cnt < `EWSC_TX_WIN_TICKS);
    if (tx_qual) begin
      st_next.tx_armed = 1'b0;
    end else if (tx_rise) begin
      st_next.tx_armed = 1'b1;
      st_next.tx_cnt = '0;
    end else if (st_reg.tx_armed) begin
      if (st_reg.tick) begin
        st_next.tx_cnt = st_reg.tx_cnt + 16'h0001;
      end
      if (st_reg.tx_cnt >= `EWSC_TX_WIN_TICKS) begin
        st_next.tx_armed = 1'b0;
      end
    end

    st_next.ul_cnt = hold_cnt(e.key_unlock, st_reg.tick, st_reg.ul_cnt, `EWSC_KEY_OPEN_TICKS);
    st_next.lk_cnt = hold_cnt(e.key_lock, st_reg.tick, st_reg.lk_cnt, `EWSC_KEY_CLOSE_TICKS);
    st_next.req_cnt = hold_cnt(e.req_sw & e.card_in_range, st_reg.tick, st_reg.req_cnt, `EWSC_REQ_CLOSE_TICKS);
    ul_q = st_reg.ul_cnt == `EWSC_KEY_OPEN_TICKS;
    lk_q = st_reg.lk_cnt == `EWSC_KEY_CLOSE_TICKS;
    req_q = st_reg.req_cnt == `EWSC_REQ_CLOSE_TICKS;

    // exterior request arbitration
    if (inhibit || (st_reg.grace && interior)) begin
      st_next.ext = ewsc_pkg::EXT_IDLE;
    end else if ((|w.obstruct || |st_reg.rev) &&
                 (st_reg.ext == ewsc_pkg::EXT_KEY_CLOSE || st_reg.ext == ewsc_pkg::EXT_REQ_CLOSE)) begin
      st_next.ext = ewsc_pkg::EXT_IDLE;
    end else begin
      case (st_reg.ext)
        ewsc_pkg::EXT_IDLE, ewsc_pkg::EXT_REQ_CLOSE: begin
          if (tx_qual && open_ok) begin
            st_next.ext = ewsc_pkg::EXT_TX_OPEN;
          end else if (ul_q && open_ok) begin
            st_next.ext = ewsc_pkg::EXT_KEY_AUTO_OPEN;
            st_next.key_rel = 1'b0;
          end else if (lk_q && !closed_all) begin
            st_next.ext = ewsc_pkg::EXT_KEY_CLOSE;
          end else if (st_reg.ext == ewsc_pkg::EXT_IDLE) begin
            if (req_q && !closed_all) begin
              st_next.ext = ewsc_pkg::EXT_REQ_CLOSE;
            end
          end else if (!(e.req_sw && e.card_in_range) || closed_all) begin
            st_next.ext = ewsc_pkg::EXT_IDLE;
          end
        end
        ewsc_pkg::EXT_TX_OPEN: begin
          if (!e.tx_unlock || !open_ok) begin
            st_next.ext = ewsc_pkg::EXT_IDLE;
          end
        end
        ewsc_pkg::EXT_KEY_AUTO_OPEN: begin
          if (!e.key_unlock && !e.key_lock) begin
            st_next.key_rel = 1'b1;
          end
          if (st_reg.key_rel && (e.key_unlock || e.key_lock)) begin
            st_next.ext = ewsc_pkg::EXT_HALT;
          end else if (!open_ok) begin
            st_next.ext = ewsc_pkg::EXT_IDLE;
          end
        end
        ewsc_pkg::EXT_KEY_CLOSE: begin
          if (!e.key_lock || closed_all) begin
            st_next.ext = ewsc_pkg::EXT_IDLE;
          end
        end
        ewsc_pkg::EXT_HALT: begin
          // wait for neutral so the halting turn cannot start a new hold
          if (!e.key_unlock && !e.key_lock) begin
            st_next.ext = ewsc_pkg::EXT_IDLE;
          end
        end
        default: begin
          st_next.ext = ewsc_pkg::EXT_IDLE;
        end
      endcase
    end

    opening = st_next.ext == ewsc_pkg::EXT_TX_OPEN || st_next.ext == ewsc_pkg::EXT_KEY_AUTO_OPEN;
    closing = st_next.ext == ewsc_pkg::EXT_KEY_CLOSE || st_next.ext == ewsc_pkg::EXT_REQ_CLOSE;
    st_next.win_req.open = opening & ~e.glass_full_open;
    st_next.win_req.close = closing & ~e.glass_closed;
    st_next.roof.open = opening & ~e.roof_full_open;
    st_next.roof.close = closing & ~e.roof_closed;

    // front windows: hall decode, position, automatic and reversal
    st_next.a_prev = h.a;
    st_next.b_prev = h.b;
    st_next.ao_prev = w.auto_open;
    st_next.ac_prev = w.auto_close;
    for (int f = 0; f < 2; f++) begin
      a_edge = h.a[f] ^ st_reg.a_prev[f];
      b_edge = h.b[f] ^ st_reg.b_prev[f];
      a_rise = h.a[f] & ~st_reg.a_prev[f];
      moving = st_reg.win_open[f] | st_reg.win_close[f];
      fail_set = 1'b0;
      if (st_reg.period_cnt[f] != 16'hFFFF) begin
        st_next.period_cnt[f] = st_reg.period_cnt[f] + 16'h0001;
      end
      if (a_rise) begin
        st_next.period[f] = st_reg.period_cnt[f];
        st_next.period_cnt[f] = '0;
        if (st_reg.valid[f]) begin
          if (!h.b[f] && st_reg.pos[f] != FULL_OPEN_PULSES) begin
            st_next.pos[f] = st_reg.pos[f] + `EWSC_POS_W'(1);
          end else if (h.b[f] && st_reg.pos[f] != '0) begin
            st_next.pos[f] = st_reg.pos[f] - `EWSC_POS_W'(1);
          end
        end
        if (moving && (h.b[f] == st_reg.win_open[f])) begin
          fail_set = 1'b1; // decoded direction disagrees with drive
        end
      end
      if (!moving || b_edge) begin
        st_next.a_only[f] = '0;
      end else if (a_edge) begin
        st_next.a_only[f] = st_reg.a_only[f] + 3'h1;
      end
      if (!moving || a_edge) begin
        st_next.b_only[f] = '0;
      end else if (b_edge) begin
        st_next.b_only[f] = st_reg.b_only[f] + 3'h1;
      end
      if (st_reg.a_only[f] >= `EWSC_HALL_FAIL_EDGES || st_reg.b_only[f] >= `EWSC_HALL_FAIL_EDGES) begin
        fail_set = 1'b1;
      end
      if (!moving || a_edge) begin
        st_next.stall[f] = '0;
      end else if (st_reg.tick && st_reg.stall[f] < `EWSC_STALL_TICKS) begin
        st_next.stall[f] = st_reg.stall[f] + 16'h0001;
      end
      stalled = st_reg.stall[f] == `EWSC_STALL_TICKS;

      man_o = ign_ok & w.main_open[f];
      man_c = ign_ok & w.main_close[f];
      if (f == 1) begin
        man_o = ign_ok & ~w.power_cut & (w.main_open[f] | w.sub_open[0]);
        man_c = ign_ok & ~w.power_cut & (w.main_close[f] | w.sub_close[0]);
      end

      // initial setting: manual close driven into the top stop
      if (st_reg.win_close[f] && man_c && stalled) begin
        st_next.pos[f] = '0;
        st_next.valid[f] = 1'b1;
        st_next.fail[f] = 1'b0;
      end
      st_next.fail[f] = st_next.fail[f] | fail_set; // a hall fault outranks the clear of an initial setting
      if (w.conn_lost[f]) begin
        st_next.valid[f] = 1'b0;
      end

      auto_ok = st_reg.valid[f] & ~st_reg.fail[f] & ign_ok;
      if (man_o || man_c || !auto_ok || st_reg.rev[f]) begin
        st_next.auto_o[f] = 1'b0;
        st_next.auto_c[f] = 1'b0;
      end else if (w.auto_open[f] && !st_reg.ao_prev[f]) begin
        st_next.auto_o[f] = 1'b1;
        st_next.auto_c[f] = 1'b0;
      end else if (w.auto_close[f] && !st_reg.ac_prev[f]) begin
        st_next.auto_c[f] = 1'b1;
        st_next.auto_o[f] = 1'b0;
      end else begin
        if (st_reg.pos[f] >= FULL_OPEN_PULSES || stalled) begin
          st_next.auto_o[f] = 1'b0;
        end
        if (st_reg.pos[f] == '0 || stalled) begin
          st_next.auto_c[f] = 1'b0;
        end
      end

      if (w.obstruct[f] && st_reg.win_close[f]) begin
        st_next.rev[f] = 1'b1;
        st_next.rev_left[f] = REV_PULSES;
        st_next.auto_c[f] = 1'b0;
      end else if (st_reg.rev[f]) begin
        if (a_rise) begin
          st_next.rev_left[f] = st_reg.rev_left[f] - `EWSC_POS_W'(1);
        end
        if (st_reg.rev_left[f] == '0 || stalled || st_reg.pos[f] >= FULL_OPEN_PULSES) begin
          st_next.rev[f] = 1'b0;
        end
      end

      // reversal first, then interior switch, then automatic, then exterior request
      ext_o = ~man_o & ~man_c & ~st_reg.auto_o[f] & ~st_reg.auto_c[f] & st_reg.win_req.open;
      ext_c = ~man_o & ~man_c & ~st_reg.auto_o[f] & ~st_reg.auto_c[f] & st_reg.win_req.close;
      st_next.win_open[f] = st_reg.rev[f] | man_o | (~man_c & st_reg.auto_o[f]) | ext_o;
      st_next.win_close[f] = ~st_next.win_open[f] & (man_c | st_reg.auto_c[f] | ext_c);
    end

    // rear windows: manual only
    for (int r = 2; r < 4; r++) begin
      man_o = ign_ok & ~w.power_cut & (w.main_open[r] | w.sub_open[r-1]);
      man_c = ign_ok & ~w.power_cut & (w.main_close[r] | w.sub_close[r-1]);
      st_next.win_open[r] = man_o;
      st_next.win_close[r] = man_c & ~man_o;
    end

    // register slave, one wait cycle per access
    bus_req = avs_read | avs_write;
    st_next.waitreq = ~(bus_req & st_reg.waitreq);
    if (bus_req && st_reg.waitreq) begin
      case (avs_address)
        `EWSC_OFS_CTRL: st_next.rdata = {31'h0, st_reg.ext_en};
        `EWSC_OFS_STATUS: st_next.rdata = {20'h0, st_reg.fail, st_reg.valid, st_reg.grace, st_reg.roof,
                                            st_reg.win_req, st_reg.ext};
        `EWSC_OFS_POS: st_next.rdata = {4'h0, st_reg.pos[1], 4'h0, st_reg.pos[0]};
        `EWSC_OFS_SPEED: st_next.rdata = {st_reg.period[1], st_reg.period[0]};
        default: st_next.rdata = 32'h0;
      endcase
    end
    if (avs_write && !st_reg.waitreq && avs_address == `EWSC_OFS_CTRL) begin
      st_next.ext_en = avs_writedata[`EWSC_CTRL_EN_BIT];
      if (avs_writedata[`EWSC_CTRL_INVAL_BIT]) begin
        st_next.valid = '0; // forces a new initial setting
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.ext <= ewsc_pkg::EXT_IDLE;
      st_reg.ext_en <= `EWSC_CTRL_RESET;
      st_reg.waitreq <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign win_req = st_reg.win_req;
  assign roof_cmd = st_reg.roof;
  assign win_open = st_reg.win_open;
  assign win_close = st_reg.win_close;
endmodule : ewsc_top

// [inc/ewsc_params.svh]
// constants of the exterior window and sunroof controller
// What this block does
// - transmitter unlock, second press within 1.5 s held, opens manually until release
// - key held in unlock about 2.2 s starts automatic opening to fully open
// - key held in lock about 1.5 s closes manually until key returns neutral
// - any further key operation during key automatic opening halts glass and sunroof
// - request switch held 1.5 s with card key in range closes manually
// - qualified key or transmitter request replaces a running request-switch close
// - during 40 s ignition-off grace, interior switches beat exterior requests
// - obstruction reversal beats any exterior close in progress
// - door open, key inserted, ignition on or transmitter away blocks and stops operation
// - body controller sends window request and drives sunroof motor directly
// - locked power-cut ignores main switch manual for other doors and all sub-switches, not the front automatic
// - main switch: manual all windows, automatic fronts only; sub-switch: own window
// - battery, fuse or connector loss invalidates position; initial setting needed
// - motor speed comes from first hall sensor, one cycle per axle turn
// - rotation direction comes from phase order of the two hall signals
// - until initialised only manual operation; switch automatic refused, key automatic opening still runs
// - one hall sensor pulsing without the other enters fail-safe, no switch automatic; key automatic opening still runs
// - obstruction during automatic close drives the window open about 200 mm
`ifndef EWSC_PARAMS_SVH
`define EWSC_PARAMS_SVH
`define EWSC_CLK_HZ 50000000
`define EWSC_TICK_MS 1
`define EWSC_TICK_CYCLES (`EWSC_CLK_HZ / 1000 * `EWSC_TICK_MS)
`define EWSC_TX_WIN_MS 1500
`define EWSC_KEY_OPEN_MS 2200
`define EWSC_KEY_CLOSE_MS 1500
`define EWSC_REQ_CLOSE_MS 1500
`define EWSC_GRACE_S 40
`define EWSC_DEBOUNCE_MS 10
`define EWSC_STALL_MS 100
`define EWSC_TX_WIN_TICKS 16'(`EWSC_TX_WIN_MS / `EWSC_TICK_MS)
`define EWSC_KEY_OPEN_TICKS 16'(`EWSC_KEY_OPEN_MS / `EWSC_TICK_MS)
`define EWSC_KEY_CLOSE_TICKS 16'(`EWSC_KEY_CLOSE_MS / `EWSC_TICK_MS)
`define EWSC_REQ_CLOSE_TICKS 16'(`EWSC_REQ_CLOSE_MS / `EWSC_TICK_MS)
`define EWSC_STALL_TICKS 16'(`EWSC_STALL_MS / `EWSC_TICK_MS)
`define EWSC_GRACE_TICKS (`EWSC_GRACE_S * 1000 / `EWSC_TICK_MS)
`define EWSC_DB_CYCLES (`EWSC_CLK_HZ / 1000 * `EWSC_DEBOUNCE_MS)
`define EWSC_HALL_DB_CYCLES 2
`define EWSC_REV_MM 200
`define EWSC_PULSES_PER_MM 1
`define EWSC_FULL_OPEN_PULSES 12'h200
`define EWSC_HALL_FAIL_EDGES 3'h3
`define EWSC_POS_W 12
`define EWSC_DB_W 20
`define EWSC_OFS_CTRL 4'h0
`define EWSC_OFS_STATUS 4'h4
`define EWSC_OFS_POS 4'h8
`define EWSC_OFS_SPEED 4'hC
`define EWSC_CTRL_EN_BIT 0
`define EWSC_CTRL_INVAL_BIT 1
`define EWSC_CTRL_RESET 1'h1
`endif

// [inc/ewsc_pkg.sv]
// types of the exterior window and sunroof controller
`include "ewsc_params.svh"
package ewsc_pkg;
  typedef enum logic [2:0] {EXT_IDLE, EXT_TX_OPEN, EXT_KEY_AUTO_OPEN, EXT_KEY_CLOSE, EXT_REQ_CLOSE, EXT_HALT}
    ewsc_ext_state_t;

  typedef struct packed {
    logic open;
    logic close;
  } ewsc_cmd_t;

  typedef struct packed {
    logic tx_unlock;
    logic key_unlock;
    logic key_lock;
    logic req_sw;
    logic card_in_range;
    logic door_open;
    logic key_inserted;
    logic ign_on;
    logic tx_out_of_range;
    logic glass_full_open;
    logic glass_closed;
    logic roof_full_open;
    logic roof_closed;
  } ewsc_ext_in_t;

  typedef struct packed {
    logic [3:0] main_open;
    logic [3:0] main_close;
    logic [2:0] sub_open;
    logic [2:0] sub_close;
    logic [1:0] auto_open;
    logic [1:0] auto_close;
    logic power_cut;
    logic [1:0] obstruct;
    logic [1:0] conn_lost;
  } ewsc_win_in_t;

  typedef struct packed {
    logic [1:0] a;
    logic [1:0] b;
  } ewsc_hall_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic q;
    logic [`EWSC_DB_W-1:0] cnt;
  } ewsc_db_state_t;

  typedef struct packed {
    ewsc_ext_state_t ext;
    logic [15:0] tick_cnt;
    logic tick;
    logic tx_prev;
    logic tx_armed;
    logic [15:0] tx_cnt;
    logic [15:0] ul_cnt;
    logic [15:0] lk_cnt;
    logic [15:0] req_cnt;
    logic key_rel;
    logic ign_prev;
    logic grace;
    logic [15:0] grace_cnt;
    ewsc_cmd_t win_req;
    ewsc_cmd_t roof;
    logic [3:0] win_open;
    logic [3:0] win_close;
    logic [1:0] a_prev;
    logic [1:0] b_prev;
    logic [1:0] valid;
    logic [1:0] fail;
    logic [1:0] rev;
    logic [1:0] auto_o;
    logic [1:0] auto_c;
    logic [1:0] ao_prev;
    logic [1:0] ac_prev;
    logic [1:0][`EWSC_POS_W-1:0] pos;
    logic [1:0][`EWSC_POS_W-1:0] rev_left;
    logic [1:0][15:0] period_cnt;
    logic [1:0][15:0] period;
    logic [1:0][2:0] a_only;
    logic [1:0][2:0] b_only;
    logic [1:0][15:0] stall;
    logic ext_en;
    logic waitreq;
    logic [31:0] rdata;
  } ewsc_state_t;
endpackage : ewsc_pkg

// [rtl/ewsc_debounce.sv]
// two-flop synchroniser and stability filter for one pin
`timescale 1ns/10ps
`include "ewsc_params.svh"
module ewsc_debounce #(
  parameter logic [`EWSC_DB_W-1:0] DB_CYCLES = `EWSC_DB_W'(`EWSC_DB_CYCLES)
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic pin,
  output logic q
);
  ewsc_pkg::ewsc_db_state_t st_reg;
  ewsc_pkg::ewsc_db_state_t st_next;

  // s1 feeds s2 only; filter looks at s2
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    if (st_reg.s2 == st_reg.q) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= DB_CYCLES - `EWSC_DB_W'(1)) begin
      st_next.q = st_reg.s2;
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + `EWSC_DB_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;
endmodule : ewsc_debounce

// [verif/ewsc_top_asserts.sv]
// port checker of the exterior window controller
`timescale 1ns/10ps
module ewsc_top_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire ewsc_pkg::ewsc_ext_in_t ext_in,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire ewsc_pkg::ewsc_cmd_t win_req,
  input wire ewsc_pkg::ewsc_cmd_t roof_cmd,
  input wire logic [3:0] win_open,
  input wire logic [3:0] win_close
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // eight cycles cover sync plus filter plus state register
  sequence s_door; ext_in.door_open [*8]; endsequence
  sequence s_ign; ext_in.ign_on [*8]; endsequence
  sequence s_no_close; (!ext_in.key_lock && !ext_in.req_sw) [*8]; endsequence
  AST_WIN_EXCL: assert property ((win_open & win_close) == 4'h0) else $error("motor both ways");
  AST_REQ_EXCL: assert property (!(win_req.open && win_req.close)) else $error("request both ways");
  AST_ROOF_EXCL: assert property (!(roof_cmd.open && roof_cmd.close)) else $error("roof both ways");
  AST_BUS_ANS: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("bus answer too long");
  AST_DOOR_STOP: assert property (s_door |=> win_req == 2'h0 && roof_cmd == 2'h0) else $error("door open runs");
  AST_IGN_STOP: assert property (s_ign |=> win_req == 2'h0 && roof_cmd == 2'h0) else $error("ignition on runs");
  AST_CLOSE_REL: assert property (s_no_close |=> !win_req.close && !roof_cmd.close)
    else $error("close without hold");
endmodule : ewsc_top_asserts

bind ewsc_top ewsc_top_asserts u_chk (.clk(clk), .srst(srst), .ext_in(ext_in), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .win_req(win_req), .roof_cmd(roof_cmd),
  .win_open(win_open), .win_close(win_close));

// [verif/ewsc_motor_model.sv]
// hall sensor model of the two front window motors
`timescale 1ns/10ps
module ewsc_motor_model (
  input wire logic clk,
  input wire logic [3:0] win_open,
  input wire logic [3:0] win_close,
  output ewsc_pkg::ewsc_hall_t hall
);
  logic [1:0][3:0] ph;
  initial ph = '0;
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (win_open[i]) ph[i] <= ph[i] + 4'h1;
      else if (win_close[i]) ph[i] <= ph[i] - 4'h1;
    end
  end
  // sensors hold their level when the motor stands, as real ones do
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      hall.a[i] = ph[i][3] ^ ph[i][2];
      hall.b[i] = ph[i][3];
    end
  end
endmodule : ewsc_motor_model

// [verif/ewsc_top_test.sv]
// testbench of the exterior window controller
`timescale 1ns/10ps
module ewsc_top_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  ewsc_pkg::ewsc_ext_in_t ext_in;
  ewsc_pkg::ewsc_win_in_t win_in;
  ewsc_pkg::ewsc_hall_t hall;
  logic [3:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  ewsc_pkg::ewsc_cmd_t win_req, roof_cmd;
  logic [3:0] win_open, win_close;
  int error_cnt = 0;
  int check_count = 0;
  always #10 clk = ~clk;
  // short tick and filter keep the long holds affordable
  ewsc_top #(.TICK_CYCLES(16'h000A), .GRACE_TICKS(16'h0032), .DB_CYCLES(20'h00003)) uut (.clk(clk),
    .srst(srst), .ext_in(ext_in), .win_in(win_in), .hall_in(hall), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .win_req(win_req), .roof_cmd(roof_cmd), .win_open(win_open),
    .win_close(win_close));
  ewsc_motor_model u_motor (.clk(clk), .win_open(win_open), .win_close(win_close), .hall(hall));
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task t_regs;
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h00000001);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h00000000);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h00000000);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h00000000);
    bus(1'b1, 4'h0, 32'h00000001);
    $display("test regs done");
  endtask : t_regs
  task t_key_close;
    ext_in.key_lock <= 1'b1;
    cyc(14900);
    chk({30'h0, win_req}, 32'h0);
    for (int i = 0; i < 300 && win_req === 2'h0; i++) @(posedge clk);
    chk({28'h0, win_req, roof_cmd}, 32'h5);
    cyc(2);
    chk({24'h0, win_open, win_close}, 32'h00000003);
    ext_in.door_open <= 1'b1;
    ext_in.ign_on <= 1'b1;
    cyc(12);
    chk({28'h0, win_req, roof_cmd}, 32'h0);
    ext_in.door_open <= 1'b0;
    ext_in.ign_on <= 1'b0;
    ext_in.key_lock <= 1'b0;
    cyc(20);
    $display("test key close done");
  endtask : t_key_close
  task t_tx;
    ext_in.tx_unlock <= 1'b1;
    cyc(20);
    ext_in.tx_unlock <= 1'b0;
    cyc(100);
    ext_in.tx_unlock <= 1'b1;
    for (int i = 0; i < 300 && win_req === 2'h0; i++) @(posedge clk);
    chk({28'h0, win_req, roof_cmd}, 32'hA);
    ext_in.tx_unlock <= 1'b0;
    cyc(15);
    chk({28'h0, win_req, roof_cmd}, 32'h0);
    $display("test transmitter done");
  endtask : t_tx
  task t_key_open;
    ext_in.key_unlock <= 1'b1;
    cyc(21900);
    chk({30'h0, win_req}, 32'h0);
    for (int i = 0; i < 300 && win_req === 2'h0; i++) @(posedge clk);
    chk({28'h0, win_req, roof_cmd}, 32'hA);
    ext_in.key_unlock <= 1'b0;
    cyc(50);
    chk({28'h0, win_req, roof_cmd}, 32'hA);
    ext_in.key_lock <= 1'b1;
    cyc(20);
    chk({28'h0, win_req, roof_cmd}, 32'h0);
    ext_in.key_lock <= 1'b0;
    $display("test key open done");
  endtask : t_key_open
  initial begin
    ext_in = '0;
    win_in = '0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    cyc(20);
    srst <= 1'b0;
    t_regs;
    t_key_close;
    t_tx;
    t_key_open;
    give_verdict;
  end
  initial begin
    #1000000;
    error_cnt++;
    give_verdict;
  end
endmodule : ewsc_top_test
